// file: src/dpw_host.sv
// Purpose: Host controller issuing write cycles to one port of a dual-port RAM
// Assumes: Single clock; request held with data until accepted
// Notes:   Timing counts come from the slowest grade; parameters may shorten them
`include "dpw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dpw_host
   import dpw_pkg::*;
#(
   parameter int ADDR_W    = 10,
   parameter int DATA_W    = 8,
   parameter int T_WP_NS   = `DPW_T_WP_NS,
   parameter int T_EW_NS   = `DPW_T_EW_NS,
   parameter int T_AW_NS   = `DPW_T_AW_NS,
   parameter int T_DW_NS   = `DPW_T_DW_NS,
   parameter int T_WZ_NS   = `DPW_T_WZ_NS,
   parameter int T_BAA_NS  = `DPW_T_BAA_NS
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              wr_req,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              keep_oe_low,
   input  wire logic              master_slave,
   output logic                   wr_ready,
   output logic                   wr_done,
   output var dpw_pins_s          pins
);

   // ======================================================================
   // Cycle counts
   // Data may not be driven while outputs can still be on, so data setup
   // starts only after the turn-off time when output enable is low.
   // Counts are four bits wide, so no single phase may need more than
   // fifteen cycles; faster clocks or longer timings need a wider counter.
   localparam int C_WP   = `DPW_CYC(T_WP_NS);
   localparam int C_EW   = `DPW_CYC(T_EW_NS);
   localparam int C_AW   = `DPW_CYC(T_AW_NS);
   localparam int C_DW   = `DPW_CYC(T_DW_NS);
   localparam int C_WZ   = `DPW_CYC(T_WZ_NS);
   localparam int C_BAA  = `DPW_CYC(T_BAA_NS);
   localparam int C_BASE = `DPW_MAX(`DPW_MAX(C_WP, C_EW), `DPW_MAX(C_AW, C_DW));
   localparam int C_OEL  = `DPW_MAX(C_BASE, C_WZ + C_DW);
   localparam logic [`DPW_CNT_W-1:0] N_BASE = C_BASE[`DPW_CNT_W-1:0];
   localparam logic [`DPW_CNT_W-1:0] N_OEL  = C_OEL[`DPW_CNT_W-1:0];
   localparam logic [`DPW_CNT_W-1:0] N_WZ   = C_WZ[`DPW_CNT_W-1:0];
   localparam logic [`DPW_CNT_W-1:0] N_BAA  = C_BAA[`DPW_CNT_W-1:0];

   // ======================================================================
   // State decodes
   function automatic logic in_pulse(input dpw_state_e s);
      return (s == DPW_PULSE);
   endfunction : in_pulse

   function automatic logic in_cycle(input dpw_state_e s);
      return (s != DPW_IDLE);
   endfunction : in_cycle

   // ======================================================================
   // Sequencer
   dpw_state_e             state, next_state;
   logic [`DPW_CNT_W-1:0]  cnt, next_cnt;
   logic [ADDR_W-1:0]      addr, next_addr;
   logic [DATA_W-1:0]      data, next_data;
   logic                   oe_low, next_oe_low;
   logic                   drive, next_drive;
   logic                   done, next_done;

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_drive  = drive;
      next_done   = 1'b0;
      unique case (state)
         DPW_IDLE: begin
            if (wr_req) begin
               // Master/slave setup holds off the pulse for the busy delay
               next_cnt    = master_slave ? N_BAA : `DPW_CNT_ONE;
               next_state  = DPW_SETUP;
            end
         end
         DPW_SETUP: begin
            if (cnt <= `DPW_CNT_ONE) begin
               next_state = DPW_PULSE;
               next_cnt   = oe_low ? N_OEL : N_BASE;
               next_drive = !oe_low;
            end else begin
               next_cnt = cnt - `DPW_CNT_ONE;
            end
         end
         DPW_PULSE: begin
            // With output enable low, drive only after the turn-off time
            if (oe_low && (cnt == N_OEL - N_WZ + `DPW_CNT_ONE)) begin
               next_drive = 1'b1;
            end
            if (cnt <= `DPW_CNT_ONE) begin
               next_state = DPW_RECOVER;
            end else begin
               next_cnt = cnt - `DPW_CNT_ONE;
            end
         end
         DPW_RECOVER: begin
            // Controls rise together; data held two more cycles, through RECOVER and HOLD
            next_state = DPW_HOLD;
         end
         DPW_HOLD: begin
            next_drive = 1'b0;
            next_done  = 1'b1;
            next_state = DPW_IDLE;
         end
         default: next_state = DPW_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state  <= DPW_IDLE;
         cnt    <= '0;
         drive  <= 1'b0;
         done   <= 1'b0;
      end else begin
         state  <= next_state;
         cnt    <= next_cnt;
         drive  <= next_drive;
         done   <= next_done;
      end
   end

   // ======================================================================
   // Request capture
   // Address, data and mode are latched only at the take, while both
   // controls are high, so later changes on the request side never reach
   // the pins in mid-cycle.
   logic take;

   always_comb begin
      take        = wr_req && !in_cycle(state);
      next_addr   = addr;
      next_data   = data;
      next_oe_low = oe_low;
      if (take) begin
         // Address moves only here, with both controls high
         next_addr   = wr_addr;
         next_data   = wr_data;
         next_oe_low = keep_oe_low;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         addr   <= '0;
         data   <= '0;
         oe_low <= 1'b0;
      end else begin
         addr   <= next_addr;
         data   <= next_data;
         oe_low <= next_oe_low;
      end
   end

   // ======================================================================
   // Control pins
   // Controls come from flip-flops: a decode of the state bits could
   // glitch low between states and start a stray write in the RAM.
   // Both controls fall on one edge so chip select is never earlier than
   // read/write, keeping the port outputs off when output enable is low.
   logic ctrl_n, next_ctrl_n;
   logic oe_n,   next_oe_n;

   always_comb begin
      next_ctrl_n = !in_pulse(next_state);
      next_oe_n   = !(next_oe_low && in_cycle(next_state));
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_n <= 1'b1;
         oe_n   <= 1'b1;
      end else begin
         ctrl_n <= next_ctrl_n;
         oe_n   <= next_oe_n;
      end
   end

   // ======================================================================
   // Outputs
   assign pins.chip_sel_n = ctrl_n;
   assign pins.rw_n       = ctrl_n;
   assign pins.out_en_n   = oe_n;
   assign pins.addr       = addr;
   assign pins.data_out   = data;
   assign pins.data_oe    = drive;

   // ======================================================================
   // Handshake
   // Ready is a plain decode; a request seen while busy is dropped with
   // no indication, so the requester must wait for ready itself.
   assign wr_ready = !in_cycle(state);
   assign wr_done  = done;

endmodule : dpw_host

`default_nettype wire

// file: src/dpw_defs.svh
// Purpose: Timing constants for the dual-port RAM write-cycle host controller
// Assumes: 10 MHz clock, 100 ns period; slowest speed grade figures by default
// Notes:   Least times round up to whole cycles, never below one
`ifndef DPW_DEFS_SVH
`define DPW_DEFS_SVH

`define DPW_CLK_NS      100
// Slowest grade minimums, in ns
`define DPW_T_WP_NS     55
`define DPW_T_EW_NS     90
`define DPW_T_AW_NS     90
`define DPW_T_DW_NS     40
`define DPW_T_WZ_NS     40
`define DPW_T_WR_NS     0
`define DPW_T_BAA_NS    50
`define DPW_T_AS_NS     0
`define DPW_T_DH_NS     0

`define DPW_CYC(ns)     ((((ns) + `DPW_CLK_NS - 1) / `DPW_CLK_NS) < 1 ? 1 : \
                         (((ns) + `DPW_CLK_NS - 1) / `DPW_CLK_NS))
`define DPW_MAX(a, b)   ((a) > (b) ? (a) : (b))

`define DPW_CNT_W       4
`define DPW_CNT_ONE     4'h1

`endif

// file: src/dpw_pkg.sv
// Purpose: Types shared by the dual-port RAM write-cycle host controller
// Assumes: 1K x 8 port, active-low controls
// Notes:   Pin group carried as one packed struct
package dpw_pkg;

   typedef enum logic [2:0] {
      DPW_IDLE,
      DPW_SETUP,
      DPW_PULSE,
      DPW_RECOVER,
      DPW_HOLD
   } dpw_state_e;

   typedef struct packed {
      logic       chip_sel_n;
      logic       rw_n;
      logic       out_en_n;
      logic [9:0] addr;
      logic [7:0] data_out;
      logic       data_oe;
   } dpw_pins_s;

endpackage : dpw_pkg

// file: bench/dpw_ram_model.sv
// Purpose: Behavioural RAM port facing the write host
// Assumes: Zero-delay pins, the fastest legal device
// Notes:   No read cycles are modelled
`timescale 1ns/1ps
`default_nettype none
module dpw_ram_model
   import dpw_pkg::*;
(
   input  wire dpw_pins_s pins,
   output logic           port_drv
);
   logic [7:0] mem [1024];
   // Store only while both controls overlap low
   always @(pins)
      if (!pins.chip_sel_n && !pins.rw_n && pins.data_oe) mem[pins.addr] = pins.data_out;
   // Drivers off at once when read/write falls, on again with no delay
   assign port_drv = !pins.chip_sel_n && pins.rw_n && !pins.out_en_n;
endmodule : dpw_ram_model
`default_nettype wire

// file: bench/dpw_host_sva.sv
// Purpose: Pin timing checks for the write host
// Assumes: Default timing, every count one cycle except N_OEL, which is two
// Notes:   Bound into each host instance
`timescale 1ns/1ps
`default_nettype none
module dpw_host_sva
   import dpw_pkg::*;
#(parameter int ADDR_W = 10, parameter int DATA_W = 8) (
   input wire logic              clock,
   input wire logic              rst,
   input wire logic              wr_req,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              keep_oe_low,
   input wire logic              master_slave,
   input wire logic              wr_ready,
   input wire logic              wr_done,
   input wire dpw_pins_s         pins
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_addr_hold: assert property (!pins.chip_sel_n && !pins.rw_n |-> $stable(pins.addr)) else $error("addr moved");
   chk_cs_span: assert property (pins.chip_sel_n == pins.rw_n) else $error("controls split");
   chk_take_pulse: assert property (wr_req && wr_ready |=> pins.rw_n ##1 !pins.rw_n) else $error("pulse late");
   chk_short_pulse: assert property ($fell(pins.rw_n) && pins.out_en_n |=> pins.rw_n) else $error("pulse long");
   chk_long_pulse: assert property ($fell(pins.rw_n) && !pins.out_en_n |=> !pins.rw_n ##1 pins.rw_n)
      else $error("pulse short");
   chk_no_clash: assert property ($fell(pins.rw_n) && !pins.out_en_n |-> !pins.data_oe) else $error("clash");
   chk_data_setup: assert property ($rose(pins.rw_n) |-> $past(pins.data_oe) && $stable(pins.data_out))
      else $error("data late");
   chk_addr_move: assert property ($changed(pins.addr) |-> $past(wr_ready)) else $error("addr mid cycle");
   chk_done_gap: assert property ($rose(pins.rw_n) |-> ##2 wr_done) else $error("done late");
   chk_addr_valid: assert property ($fell(pins.rw_n) |-> $stable(pins.addr)) else $error("addr not settled");
endmodule : dpw_host_sva
bind dpw_host dpw_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (.clock(clock), .rst(rst), .wr_req(wr_req),
   .wr_addr(wr_addr), .wr_data(wr_data), .keep_oe_low(keep_oe_low), .master_slave(master_slave),
   .wr_ready(wr_ready), .wr_done(wr_done), .pins(pins));
`default_nettype wire

// file: bench/test_dpw_host.sv
// Purpose: Self-checking bench for the write host
// Assumes: Default timing parameters, 100 ns clock
// Notes:   Drives on rising edges, samples on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_dpw_host
   import dpw_pkg::*;
;
   logic       clock = 1'b0, rst = 1'b1, wr_req = 1'b0, keep_oe_low = 1'b0, master_slave = 1'b0;
   logic [9:0] wr_addr = '0;
   logic [7:0] wr_data = '0;
   logic       wr_ready, wr_done, port_drv;
   dpw_pins_s  pins;
   int         n_mismatch = 0, check_count = 0, cycles = 0;
   dpw_host dut (.clock(clock), .rst(rst), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
      .keep_oe_low(keep_oe_low), .master_slave(master_slave), .wr_ready(wr_ready), .wr_done(wr_done), .pins(pins));
   dpw_ram_model u_ram (.pins(pins), .port_drv(port_drv));
   initial forever #50 clock = ~clock;
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // A poke raises a second request while busy; it must be ignored
   task automatic do_write(input logic [9:0] a, input logic [7:0] d, input logic oe, input logic ms,
                           input logic poke, input logic [9:0] exp_lat);
      logic [9:0] lat;
      lat = '0;
      @(posedge clock);
      wr_req <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      keep_oe_low <= oe;
      master_slave <= ms;
      do begin
         @(posedge clock);
         wr_req <= (lat == 10'd0) && poke;
         wr_addr <= a ^ 10'h001;
         wr_data <= ~d;
         @(negedge clock);
         lat++;
      end while (wr_done !== 1'b1 && lat < 10'd20);
      if (exp_lat != 10'd0) check(lat, exp_lat);
      check({2'b00, u_ram.mem[a]}, {2'b00, d});
   endtask : do_write
   task automatic t_short();
      do_write(10'h000, 8'h5a, 1'b0, 1'b0, 1'b0, 10'd5);
      do_write(10'h3ff, 8'ha5, 1'b0, 1'b0, 1'b0, 10'd5);
      check({2'b00, u_ram.mem[10'h000]}, 10'h05a);
   endtask : t_short
   task automatic t_long();
      do_write(10'h155, 8'h11, 1'b1, 1'b0, 1'b0, 10'd6);
   endtask : t_long
   task automatic t_ms();
      do_write(10'h2aa, 8'hc3, 1'b0, 1'b1, 1'b0, 10'd5);
   endtask : t_ms
   task automatic t_refuse();
      do_write(10'h154, 8'h77, 1'b1, 1'b0, 1'b1, 10'd6);
      check({2'b00, u_ram.mem[10'h155]}, 10'h011);
   endtask : t_refuse
   always @(negedge clock)
      if (port_drv === 1'b1) check({9'h000, pins.data_oe}, 10'h000);
   // Whole run is under 100 cycles; the ceiling leaves wide margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_short();
      t_long();
      t_ms();
      t_refuse();
      final_report();
   end
endmodule : test_dpw_host
`default_nettype wire
